// ### tb/ltak_cmd_asserts.sv
// Checker for the key and authentication command block
`timescale 1ns/1ps
module ltak_cmd_asserts
  import ltak_pkg::*;
  #(parameter int RESP_DELAY = 50)
  (
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_frame,
    input wire logic up_bit,
    input wire logic up_active,
    input wire logic aes_start,
    input wire ltak_pkg::ltak_aes_req_type aes_req,
    input wire logic nvm_wr_strobe,
    input wire ltak_pkg::ltak_nvm_wr_type nvm_wr,
    input wire logic nvm_wr_ack,
    input wire logic field_supply_off
  );
  localparam int DLY_MAX = RESP_DELAY + 40;
  int dly_reg;
  // Cycles since the request frame ended, saturating
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      dly_reg <= 0;
    else if (link_frame)
      dly_reg <= 0;
    else if (dly_reg < RESP_DELAY)
      dly_reg <= dly_reg + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  resp_delay_a: assert property ($rose(up_active) |-> dly_reg == RESP_DELAY)
    else $error("response too early");
  resp_bound_a: assert property ($fell(link_frame) |-> ##[1:DLY_MAX] $rose(up_active))
    else $error("response too late");
  resp_start_a: assert property ($rose(up_active) |-> up_bit)
    else $error("response starts low");
  resp_end_a: assert property ($fell(up_active) |-> !up_bit)
    else $error("uplink not idle low");
  copy_step_a: assert property (nvm_wr_strobe && nvm_wr_ack |=>
    !nvm_wr_strobe || nvm_wr.addr == $past(nvm_wr.addr) + KEY_COPY_STRIDE)
    else $error("copy address step wrong");
  nvm_hold_a: assert property (nvm_wr_strobe && !nvm_wr_ack |=>
    nvm_wr_strobe && $stable(nvm_wr)) else $error("write dropped before ack");
  aes_pulse_a: assert property (aes_start |=> !aes_start)
    else $error("cipher start too long");
  aes_hold_a: assert property (!aes_start |-> $stable(aes_req))
    else $error("cipher request moved");
  supply_hold_a: assert property ($past(resetn, 2) |-> $stable(field_supply_off))
    else $error("supply switch moved");
  cover property ($rose(up_active));
  cover property (nvm_wr_strobe && nvm_wr_ack);
  cover property (aes_start && aes_req.bilateral);
endmodule // ltak_cmd_asserts

bind ltak_cmd ltak_cmd_asserts #(.RESP_DELAY(RESP_DELAY)) u_chk (.clk, .resetn, .link_frame,
  .up_bit, .up_active, .aes_start, .aes_req, .nvm_wr_strobe, .nvm_wr, .nvm_wr_ack,
  .field_supply_off);

// ### tb/ltak_reader.sv
// Base station model sending request frames on the downlink
`timescale 1ns/1ps
module ltak_reader
  (
    input wire logic clk,
    output logic link_clk,
    output logic link_frame,
    output logic link_data
  );
  initial
  begin
    link_clk = 1'b0;
    link_frame = 1'b0;
    link_data = 1'b0;
  end
  // Sends v[n-1:0] MSB first
  task automatic send(input logic [159:0] v, input int n);
    @(posedge clk);
    link_frame <= 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      link_data <= v[i];
      repeat (4) @(posedge clk);
      link_clk <= 1'b1;
      repeat (4) @(posedge clk);
      link_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    link_frame <= 1'b0;
    link_data <= ~v[0];
  endtask
endmodule // ltak_reader

// ### tb/testbench.sv
// Self-checking bench for the key and authentication command block
`timescale 1ns/1ps
module testbench;
  import ltak_pkg::*;
  localparam int RD = 50;
  localparam int EH = 20;
  localparam logic [127:0] AESR = {16'hC3A5, 112'h5A3C};
  localparam logic [127:0] KEY = 128'h89ABCDEF_76543210;
  localparam logic [103:0] CHAL = 104'h11223344556677889900AABBCC;
  logic clk;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, link_clk, link_frame, link_data, up_bit, up_active, aes_start;
  logic aes_done = 1'b0;
  logic nvm_wr_ack = 1'b0;
  logic enh_flag_stored = 1'b0;
  logic nvm_wr_strobe, field_supply_off;
  ltak_aes_req_type aes_req, areq;
  ltak_nvm_wr_type nvm_wr;
  ltak_nvm_wr_type nq[$];
  int n_fail = 0;
  int checks = 0;
  ltak_cmd #(.RESP_DELAY(RD), .ERR_HALF(EH)) DUT (.clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .link_clk,
    .link_frame, .link_data, .up_bit, .up_active, .aes_start, .aes_req, .aes_done,
    .aes_result(AESR), .nvm_wr_strobe, .nvm_wr, .nvm_wr_ack, .enh_flag_stored,
    .field_supply_off);
  ltak_reader rdr (.clk, .link_clk, .link_frame, .link_data);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cipher and memory models
  always @(posedge clk)
  begin
    aes_done <= aes_start;
    if (aes_start)
      areq <= aes_req;
    nvm_wr_ack <= nvm_wr_strobe && !nvm_wr_ack;
    if (nvm_wr_strobe && nvm_wr_ack)
      nq.push_back(nvm_wr);
  end
  // --------------------
  // Tasks
  // --------------------
  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [159:0] seen, input logic [159:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(nm, q, e);
  endtask
  function automatic logic [7:0] crc8(input logic [127:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = n - 1; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC8_POLY : 8'h00);
    return c;
  endfunction
  task automatic frame(input logic [7:0] h, input logic [127:0] p, input int n);
    logic [159:0] v;
    v = ({152'h0, h} << (n + 8)) | ({32'h0, p} << 8) | crc8(p, n);
    if (n == 0)
      v = {152'h0, h};
    rdr.send(v, n == 0 ? 8 : n + 16);
  endtask
  task automatic wup(input logic lvl);
    for (int i = 0; i < 70000 && up_active !== lvl; i++)
      @(posedge clk);
  endtask
  task automatic errw(input logic [7:0] st);
    wup(1'b1);
    chk("wave start", up_bit, 1'b1);
    repeat (EH + EH / 2) @(posedge clk);
    chk("wave toggle", up_bit, 1'b0);
    wup(1'b0);
    rdc("error status", REG_STATUS, st);
  endtask
  task automatic upl(output logic [23:0] v);
    wup(1'b1);
    repeat (UP_BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 24; i++)
    begin
      v = {v[22:0], up_bit};
      repeat (UP_BIT_CYC) @(posedge clk);
    end
  endtask
  task automatic rst();
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    nq.delete();
    repeat (4) @(posedge clk);
  endtask
  task automatic waitq(input int n);
    for (int i = 0; i < 3000 && nq.size() < n; i++)
      @(posedge clk);
  endtask
  // --------------------
  // Tests
  // --------------------
  initial
  begin
    logic [23:0] r;
    rst();
    rdc("cfg", REG_CFG, CFG_RST);
    rdc("chal len", REG_CHAL_LEN, CHAL_LEN_RST);
    rdc("resp len", REG_RESP_LEN, RESP_LEN_RST);
    rdc("unmapped", 5'h10, 32'h0);
    wr(REG_STATUS, 8'hFF);
    avs_byteenable <= 4'h0;
    wr(REG_CFG, 8'hFF);
    avs_byteenable <= 4'h1;
    rdc("status", REG_STATUS, 32'h0);
    rdc("cfg kept", REG_CFG, CFG_RST);
    wr(REG_CFG, 8'h44);
    wr(REG_CHAL_LEN, 8'h68);
    wr(REG_RESP_LEN, 8'h08);
    $display("test registers done");
    frame({CMD_KEY2, 4'h0}, KEY, 128);
    errw({CMD_KEY2, ST_BAD_CHECK});
    frame({CMD_KEY1, CHK_KEY1}, 128'h5A, 8);
    errw({CMD_KEY1, ST_BAD_LEN});
    $display("test errors done");
    frame({CMD_AUTH, CHK_AUTH}, CHAL, 104);
    upl(r);
    chk("auth resp", r, {RESP_HEADER, AESR[127:120], crc8(AESR[127:120], 8)});
    chk("auth model", areq.bilateral, 1'b1);
    chk("auth data", areq.data, {24'h0, CHAL});
    rdc("auth status", REG_STATUS, {CMD_AUTH, ST_OK});
    $display("test auth done");
    frame({CMD_KEY1, CHK_KEY1}, KEY, 128);
    waitq(3);
    chk("key decrypt", areq.decrypt, 1'b1);
    chk("key data", areq.data, KEY);
    for (int i = 0; i < 3; i++)
      chk("key copy", nq[i], {KEY_AREA_ZERO_ADDR + KEY_COPY_STRIDE * i, AESR});
    rst();
    $display("test key done");
    frame({CMD_ENH, CHK_ENH}, 128'h0, 0);
    waitq(1);
    repeat (100) @(posedge clk);
    chk("flag writes", nq.size(), 1);
    chk("flag write", nq[0], {ENH_FLAG_ADDR, ENH_FLAG_SET});
    enh_flag_stored <= 1'b1;
    rst();
    rdc("supply status", REG_STATUS, 32'h200);
    chk("supply off", field_supply_off, 1'b1);
    $display("test enhanced done");
    conclude();
  end
  initial
  begin
    #9_000_000;
    n_fail++;
    conclude();
  end
endmodule // testbench

// ### verilog/ltak_cmd.sv
// Command decoder and executor for authentication, key learning and enhanced mode
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps

// Contract
// (RQ1) Auth request 0001/0011 starts challenge-response
// (RQ2) Challenge length from configured length register
// (RQ3) Response length from configured length register
// (RQ4) Config bit 2 selects unilateral or bilateral
// (RQ5) Reader sends 104 or 128 bit challenges
// (RQ6) Response payload typically 56 or 80 bits
// (RQ7) Response: header FE, payload, check byte
// (RQ8) Auth output is truncated AES-128 result
// (RQ9) Key1 request 0111/1001 with 128-bit key
// (RQ10) Config bit 6 selects plain or encrypted keys
// (RQ11) Key1 stored at 7C0 plus two copies
// (RQ12) Key2 request 1000/1011 with 128-bit key
// (RQ13) Key2 stored at 780 plus two copies
// (RQ14) Status high nibble echoes last command
// (RQ15) Status low nibble holds result code
// (RQ16) Status byte volatile, updated every session
// (RQ17) Key and enhanced responses: one status byte
// (RQ18) Enhanced request 0011/0101, no payload
// (RQ19) Enhanced command sets nonvolatile flag once
// (RQ20) Flag read at reset sets supply switch
// (RQ21) Request opens with command and check nibble
// (RQ22) Response starts 2 ms after request end
// (RQ23) Errors send 1 kHz wave, cause recorded
// (RQ24) Payload followed by eight-bit check value
// (RQ25) Wrong check nibble is an error
// (RQ26) Wrong payload length is an error
module ltak_cmd
  #(
    parameter int RESP_DELAY = ltak_pkg::RESP_DELAY_CYC,
    parameter int ERR_HALF = ltak_pkg::ERR_HALF_CYC
  )
  (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic link_clk,
    input wire logic link_frame,
    input wire logic link_data,
    output logic up_bit,
    output logic up_active,
    output logic aes_start,
    output ltak_pkg::ltak_aes_req_type aes_req,
    input wire logic aes_done,
    input wire logic [127:0] aes_result,
    output logic nvm_wr_strobe,
    output ltak_pkg::ltak_nvm_wr_type nvm_wr,
    input wire logic nvm_wr_ack,
    input wire logic enh_flag_stored,
    output logic field_supply_off
  );
  import ltak_pkg::*;

  localparam int PAY_W = MAX_PAY_BITS + CRC_BITS;
  localparam int TX_W = 8 + MAX_PAY_BITS;

  typedef enum {S_IDLE, S_AES, S_NVM, S_WAIT, S_SEND, S_ERR} ltak_state_type;

  // --------------------
  // Helpers
  // --------------------
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic bit_in);
    logic fb;
    fb = crc[7] ^ bit_in;
    crc8_step = {crc[6:0], 1'b0} ^ (fb ? CRC8_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] cap_len(input logic [7:0] len);
    cap_len = (len > 8'h80) ? 8'h80 : len;
  endfunction

  // --------------------
  // Declarations
  // --------------------
  ltak_state_type state_reg;
  logic lclk_meta_reg, lclk_sync_reg, lclk_prev_reg;
  logic frm_meta_reg, frm_sync_reg, frm_prev_reg;
  logic dat_meta_reg, dat_sync_reg;
  logic [7:0] hdr_reg;
  logic [3:0] hdr_cnt_reg;
  logic [PAY_W-1:0] pay_reg;
  logic [7:0] pay_cnt_reg;
  logic [7:0] rx_crc_reg;
  logic rx_ovf_reg;
  logic [7:0] cfg_reg, chal_len_reg, resp_len_reg;
  logic [7:0] status_reg;
  logic err_pend_reg;
  logic [127:0] key_buf_reg;
  logic [127:0] resp_reg;
  logic [7:0] plen_reg;
  logic [1:0] copy_idx_reg;
  logic [23:0] dly_cnt_reg;
  logic dly_run_reg;
  logic [TX_W-1:0] tx_sr_reg;
  logic [8:0] tx_idx_reg, tx_total_reg;
  logic [23:0] tx_tmr_reg;
  logic [7:0] tx_crc_reg;
  logic tx_err_reg;
  logic por_seen_reg;
  logic lclk_rise, frm_rise, frame_end, dly_done, tx_done, tx_load, err_load;
  logic [3:0] rx_cmd, rx_code, want_chk;
  logic [7:0] want_len;
  logic known_cmd;
  logic [7:0] tx_crc_nxt;

  // --------------------
  // Link input synchronisers
  // --------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lclk_meta_reg <= 1'b0;
      lclk_sync_reg <= 1'b0;
      lclk_prev_reg <= 1'b0;
      frm_meta_reg <= 1'b0;
      frm_sync_reg <= 1'b0;
      frm_prev_reg <= 1'b0;
      dat_meta_reg <= 1'b0;
      dat_sync_reg <= 1'b0;
    end
    else
    begin
      lclk_meta_reg <= link_clk;
      lclk_sync_reg <= lclk_meta_reg;
      lclk_prev_reg <= lclk_sync_reg;
      frm_meta_reg <= link_frame;
      frm_sync_reg <= frm_meta_reg;
      frm_prev_reg <= frm_sync_reg;
      dat_meta_reg <= link_data;
      dat_sync_reg <= dat_meta_reg;
    end
  end

  assign lclk_rise = lclk_sync_reg & ~lclk_prev_reg;
  assign frm_rise = frm_sync_reg & ~frm_prev_reg;
  assign frame_end = (state_reg == S_IDLE) & frm_prev_reg & ~frm_sync_reg;

  // --------------------
  // Request receiver
  // --------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hdr_reg <= 8'h00;
      hdr_cnt_reg <= 4'h0;
      pay_reg <= '0;
      pay_cnt_reg <= 8'h00;
      rx_crc_reg <= 8'h00;
      rx_ovf_reg <= 1'b0;
    end
    else if (state_reg == S_IDLE)
    begin
      if (frm_rise)
      begin
        hdr_reg <= 8'h00;
        hdr_cnt_reg <= 4'h0;
        pay_reg <= '0;
        pay_cnt_reg <= 8'h00;
        rx_crc_reg <= 8'h00;
        rx_ovf_reg <= 1'b0;
      end
      else if (frm_sync_reg && lclk_rise)
      begin
        if (hdr_cnt_reg < 4'h8)
        begin
          hdr_reg <= {hdr_reg[6:0], dat_sync_reg}; // see (RQ21)
          hdr_cnt_reg <= hdr_cnt_reg + 4'h1;
        end
        else if (pay_cnt_reg < 8'(PAY_W))
        begin
          pay_reg <= {pay_reg[PAY_W-2:0], dat_sync_reg};
          pay_cnt_reg <= pay_cnt_reg + 8'h01;
          rx_crc_reg <= crc8_step(rx_crc_reg, dat_sync_reg); // see (RQ24)
        end
        else
        begin
          rx_ovf_reg <= 1'b1;
        end
      end
    end
  end

  // --------------------
  // Request checking
  // --------------------
  assign rx_cmd = hdr_reg[7:4];

  always_comb
  begin
    known_cmd = 1'b1;
    want_chk = 4'h0;
    want_len = 8'h00;
    case (rx_cmd)
      CMD_AUTH:
      begin
        want_chk = CHK_AUTH; // see (RQ1)
        want_len = cap_len(chal_len_reg) + 8'(CRC_BITS); // see (RQ2)
      end
      CMD_KEY1:
      begin
        want_chk = CHK_KEY1; // see (RQ9)
        want_len = 8'(KEY_BITS + CRC_BITS);
      end
      CMD_KEY2:
      begin
        want_chk = CHK_KEY2; // see (RQ12)
        want_len = 8'(KEY_BITS + CRC_BITS);
      end
      CMD_ENH:
      begin
        want_chk = CHK_ENH; // see (RQ18)
        want_len = 8'h00;
      end
      default:
      begin
        known_cmd = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    if (hdr_cnt_reg != 4'h8 || !known_cmd)
      rx_code = ST_BAD_CMD;
    else if (hdr_reg[3:0] != want_chk)
      rx_code = ST_BAD_CHECK; // see (RQ25)
    else if (rx_ovf_reg || pay_cnt_reg != want_len)
      rx_code = ST_BAD_LEN; // see (RQ26)
    else if (want_len != 8'h00 && rx_crc_reg != 8'h00)
      rx_code = ST_BAD_CRC; // see (RQ24)
    else
      rx_code = ST_OK;
  end

  // --------------------
  // Command sequencer
  // --------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= S_IDLE;
      status_reg <= 8'h00;
      err_pend_reg <= 1'b0;
      key_buf_reg <= '0;
      resp_reg <= '0;
      plen_reg <= 8'h00;
      copy_idx_reg <= 2'h0;
      aes_start <= 1'b0;
      aes_req <= '0;
      nvm_wr_strobe <= 1'b0;
      nvm_wr <= '0;
    end
    else
    begin
      aes_start <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          if (frame_end)
          begin
            status_reg <= {rx_cmd, rx_code}; // see (RQ14) (RQ15) (RQ16)
            err_pend_reg <= (rx_code != ST_OK);
            resp_reg <= {rx_cmd, rx_code, 120'h0}; // see (RQ17)
            plen_reg <= STATUS_PAY_BITS;
            copy_idx_reg <= 2'h0;
            key_buf_reg <= pay_reg[PAY_W-1:CRC_BITS];
            if (rx_code != ST_OK)
              state_reg <= S_WAIT; // see (RQ23)
            else if (rx_cmd == CMD_AUTH)
            begin
              aes_start <= 1'b1; // see (RQ1) (RQ8)
              aes_req <= '{data: pay_reg[PAY_W-1:CRC_BITS], decrypt: 1'b0,
                           bilateral: cfg_reg[CFG_CM_BIT]}; // see (RQ4)
              state_reg <= S_AES;
            end
            else if (rx_cmd == CMD_ENH)
            begin
              nvm_wr_strobe <= 1'b1; // see (RQ19)
              nvm_wr <= '{addr: ENH_FLAG_ADDR, data: ENH_FLAG_SET};
              state_reg <= S_NVM;
            end
            else if (cfg_reg[CFG_SKT_BIT])
            begin
              aes_start <= 1'b1; // see (RQ10)
              aes_req <= '{data: pay_reg[PAY_W-1:CRC_BITS], decrypt: 1'b1,
                           bilateral: cfg_reg[CFG_CM_BIT]};
              state_reg <= S_AES;
            end
            else
            begin
              nvm_wr_strobe <= 1'b1; // see (RQ10) (RQ11) (RQ13)
              nvm_wr <= '{addr: (rx_cmd == CMD_KEY1) ? KEY_AREA_ZERO_ADDR : KEY_AREA_ONE_ADDR,
                          data: pay_reg[PAY_W-1:CRC_BITS]};
              state_reg <= S_NVM;
            end
          end
        end
        S_AES:
        begin
          if (aes_done)
          begin
            if (status_reg[7:4] == CMD_AUTH)
            begin
              resp_reg <= aes_result & ~({128{1'b1}} >> cap_len(resp_len_reg)); // see (RQ8)
              plen_reg <= cap_len(resp_len_reg); // see (RQ3) (RQ6)
              state_reg <= S_WAIT;
            end
            else
            begin
              key_buf_reg <= aes_result;
              nvm_wr_strobe <= 1'b1;
              nvm_wr <= '{addr: (status_reg[7:4] == CMD_KEY1) ? KEY_AREA_ZERO_ADDR
                                                              : KEY_AREA_ONE_ADDR,
                          data: aes_result};
              state_reg <= S_NVM;
            end
          end
        end
        S_NVM:
        begin
          if (nvm_wr_ack)
          begin
            if (status_reg[7:4] == CMD_ENH || copy_idx_reg == 2'h2)
            begin
              nvm_wr_strobe <= 1'b0;
              state_reg <= S_WAIT;
            end
            else
            begin
              copy_idx_reg <= copy_idx_reg + 2'h1; // see (RQ11) (RQ13)
              nvm_wr <= '{addr: nvm_wr.addr + KEY_COPY_STRIDE, data: key_buf_reg};
            end
          end
        end
        S_WAIT:
        begin
          if (dly_done)
            state_reg <= err_pend_reg ? S_ERR : S_SEND; // see (RQ22)
        end
        S_SEND, S_ERR:
        begin
          if (tx_done)
            state_reg <= S_IDLE;
        end
        default:
        begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // --------------------
  // Turnaround delay
  // --------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dly_cnt_reg <= 24'h000000;
      dly_run_reg <= 1'b0;
    end
    else if (frame_end)
    begin
      dly_cnt_reg <= 24'(RESP_DELAY - 1); // see (RQ22)
      dly_run_reg <= 1'b1;
    end
    else if (dly_run_reg && dly_cnt_reg != 24'h000000)
      dly_cnt_reg <= dly_cnt_reg - 24'h000001;
    else if (state_reg == S_WAIT)
      dly_run_reg <= 1'b0;
  end

  assign dly_done = dly_run_reg & (dly_cnt_reg == 24'h000000);
  assign tx_load = (state_reg == S_WAIT) & dly_done & ~err_pend_reg;
  assign err_load = (state_reg == S_WAIT) & dly_done & err_pend_reg;
  assign tx_done = up_active & (tx_tmr_reg == 24'h000000) & (tx_idx_reg == tx_total_reg - 9'h001);
  assign tx_crc_nxt = crc8_step(tx_crc_reg, up_bit);

  // --------------------
  // Response transmitter and error waveform
  // --------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_sr_reg <= '0;
      tx_idx_reg <= 9'h000;
      tx_total_reg <= 9'h001;
      tx_tmr_reg <= 24'h000000;
      tx_crc_reg <= 8'h00;
      tx_err_reg <= 1'b0;
      up_bit <= 1'b0;
      up_active <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_sr_reg <= {RESP_HEADER, resp_reg} << 1; // see (RQ7)
      up_bit <= RESP_HEADER[7];
      tx_total_reg <= 9'h010 + {1'b0, plen_reg};
      tx_idx_reg <= 9'h000;
      tx_crc_reg <= 8'h00;
      tx_tmr_reg <= 24'(UP_BIT_CYC - 1);
      tx_err_reg <= 1'b0;
      up_active <= 1'b1;
    end
    else if (err_load)
    begin
      up_bit <= 1'b1; // see (RQ23)
      tx_total_reg <= 9'(2 * ERR_PERIODS);
      tx_idx_reg <= 9'h000;
      tx_tmr_reg <= 24'(ERR_HALF - 1);
      tx_err_reg <= 1'b1;
      up_active <= 1'b1;
    end
    else if (up_active)
    begin
      if (tx_tmr_reg != 24'h000000)
        tx_tmr_reg <= tx_tmr_reg - 24'h000001;
      else if (tx_done)
      begin
        up_active <= 1'b0;
        up_bit <= 1'b0;
      end
      else
      begin
        tx_idx_reg <= tx_idx_reg + 9'h001;
        if (tx_err_reg)
        begin
          up_bit <= ~up_bit;
          tx_tmr_reg <= 24'(ERR_HALF - 1);
        end
        else
        begin
          tx_tmr_reg <= 24'(UP_BIT_CYC - 1);
          if (tx_idx_reg + 9'h001 == 9'h008 + {1'b0, plen_reg})
          begin
            up_bit <= tx_crc_nxt[7]; // see (RQ7) (RQ24)
            tx_sr_reg <= {tx_crc_nxt[6:0], {(TX_W-7){1'b0}}};
            tx_crc_reg <= tx_crc_nxt;
          end
          else
          begin
            up_bit <= tx_sr_reg[TX_W-1];
            tx_sr_reg <= tx_sr_reg << 1;
            if (tx_idx_reg >= 9'h008 && tx_idx_reg < 9'h008 + {1'b0, plen_reg})
              tx_crc_reg <= tx_crc_nxt;
          end
        end
      end
    end
  end

  // --------------------
  // Supply mode caught after reset release
  // --------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      por_seen_reg <= 1'b0;
      field_supply_off <= 1'b0;
    end
    else if (!por_seen_reg)
    begin
      por_seen_reg <= 1'b1;
      field_supply_off <= enh_flag_stored; // see (RQ20)
    end
  end

  // --------------------
  // Avalon-MM register slave
  // --------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      cfg_reg <= CFG_RST;
      chal_len_reg <= CHAL_LEN_RST;
      resp_len_reg <= RESP_LEN_RST;
    end
    else
    begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest)
      begin
        case (avs_address[4:2])
          REG_CFG[4:2]: avs_readdata <= {24'h000000, cfg_reg};
          REG_CHAL_LEN[4:2]: avs_readdata <= {24'h000000, chal_len_reg};
          REG_RESP_LEN[4:2]: avs_readdata <= {24'h000000, resp_len_reg};
          REG_STATUS[4:2]:
          begin
            avs_readdata <= 32'h00000000;
            avs_readdata[7:0] <= status_reg; // see (RQ14) (RQ15)
            avs_readdata[STAT_BUSY_BIT] <= (state_reg != S_IDLE);
            avs_readdata[STAT_FSO_BIT] <= field_supply_off;
          end
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      if (avs_write && !avs_waitrequest && avs_byteenable[0])
      begin
        case (avs_address[4:2])
          REG_CFG[4:2]: cfg_reg <= avs_writedata[7:0];
          REG_CHAL_LEN[4:2]: chal_len_reg <= avs_writedata[7:0];
          REG_RESP_LEN[4:2]: resp_len_reg <= avs_writedata[7:0];
          default: cfg_reg <= cfg_reg;
        endcase
      end
    end
  end

endmodule // ltak_cmd

// ### verilog/ltak_pkg.sv
// Constants and carrier types for the transponder key and authentication command block
package ltak_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESP_DELAY_NS = 2_000_000;
  localparam int RESP_DELAY_CYC = (RESP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERR_WAVE_HZ = 1000;
  localparam int ERR_HALF_CYC = 1_000_000_000 / (2 * ERR_WAVE_HZ) / CLK_PERIOD_NS;
  localparam int ERR_PERIODS = 8;
  localparam int UP_BIT_NS = 256_000;
  localparam int UP_BIT_CYC = UP_BIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int KEY_BITS = 128;
  localparam int MAX_PAY_BITS = 128;
  localparam int CRC_BITS = 8;
  localparam logic [7:0] RESP_HEADER = 8'hFE;
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [7:0] STATUS_PAY_BITS = 8'h08;

  // ----------------------------------------------------------------------
  // Commands and their check nibbles
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_AUTH = 4'h1;
  localparam logic [3:0] CHK_AUTH = 4'h3;
  localparam logic [3:0] CMD_KEY1 = 4'h7;
  localparam logic [3:0] CHK_KEY1 = 4'h9;
  localparam logic [3:0] CMD_KEY2 = 4'h8;
  localparam logic [3:0] CHK_KEY2 = 4'hB;
  localparam logic [3:0] CMD_ENH = 4'h3;
  localparam logic [3:0] CHK_ENH = 4'h5;

  // ----------------------------------------------------------------------
  // Status codes (low nibble of the status byte)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ST_OK = 4'h0;
  localparam logic [3:0] ST_BAD_CHECK = 4'h1;
  localparam logic [3:0] ST_BAD_LEN = 4'h2;
  localparam logic [3:0] ST_BAD_CRC = 4'h3;
  localparam logic [3:0] ST_BAD_CMD = 4'h4;

  // ----------------------------------------------------------------------
  // Nonvolatile locations
  // ----------------------------------------------------------------------
  localparam logic [11:0] KEY_AREA_ZERO_ADDR = 12'h7C0;
  localparam logic [11:0] KEY_AREA_ONE_ADDR = 12'h780;
  localparam logic [11:0] KEY_COPY_STRIDE = 12'h010;
  localparam logic [11:0] ENH_FLAG_ADDR = 12'h7F0;
  localparam logic [127:0] ENH_FLAG_SET = 128'h1;

  // ----------------------------------------------------------------------
  // Register map, fields and reset values
  // ----------------------------------------------------------------------
  localparam logic [4:0] REG_CFG = 5'h00;
  localparam logic [4:0] REG_CHAL_LEN = 5'h04;
  localparam logic [4:0] REG_RESP_LEN = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0C;
  localparam int CFG_CM_BIT = 2;
  localparam int CFG_SKT_BIT = 6;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_FSO_BIT = 9;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CHAL_LEN_RST = 8'h80;
  localparam logic [7:0] RESP_LEN_RST = 8'h50;

  typedef struct packed {
    logic [11:0] addr;
    logic [127:0] data;
  } ltak_nvm_wr_type;

  typedef struct packed {
    logic [127:0] data;
    logic decrypt;
    logic bilateral;
  } ltak_aes_req_type;

endpackage
